// [logic/memmap_pkg.sv]
// Purpose : Shared constants and carrier types for the banked memory map decoder.
// Assumes : One core clock; the CPU core is the only requester.
// Notes   : Offsets are bank-relative data offsets; program values are word addresses.
package memmap_pkg;

  // ------------------------------------------------------------------
  // Data side offsets and layout
  // ------------------------------------------------------------------
  localparam logic [6:0] OFF_IND_PORT  = 7'h00;  // Indirect data port.
  localparam logic [6:0] OFF_PC_LOW    = 7'h02;  // Program counter low byte.
  localparam logic [6:0] OFF_STATUS    = 7'h03;  // Core status.
  localparam logic [6:0] OFF_POINTER   = 7'h04;  // Indirect pointer.
  localparam logic [6:0] OFF_PC_LATCH  = 7'h0a;  // Program counter latch high.
  localparam logic [6:0] OFF_INT_CTRL  = 7'h0b;  // Interrupt control.
  localparam logic [6:0] STORE_BASE    = 7'h20;  // First storage offset in a bank.
  localparam logic [6:0] BANK_STORE_TOP = 7'h6f; // Last private storage offset, larger variant.
  localparam logic [6:0] SMALL_B1_TOP  = 7'h3f;  // Last bank 1 storage offset, smaller variant.
  localparam logic [6:0] COMMON_BASE   = 7'h70;  // Start of the shared common area.
  localparam logic [7:0] B1_IDX_BASE   = 8'h60;  // Physical index of bank 1 offset 20h.
  localparam logic [7:0] B2_IDX_BASE   = 8'hb0;  // Physical index of bank 2 offset 20h.
  localparam int         STORE_SMALL   = 128;    // Storage bytes, smaller variant.
  localparam int         STORE_LARGE   = 256;    // Storage bytes, larger variant.

  // ------------------------------------------------------------------
  // Core status layout and reset values
  // ------------------------------------------------------------------
  localparam int         ST_IRP        = 7;
  localparam int         ST_BANK_HI    = 6;
  localparam int         ST_BANK_LO    = 5;
  localparam logic [7:0] STATUS_RST    = 8'h18;  // Timeout and power-down flags read one.
  localparam logic [7:0] STATUS_WMASK  = 8'he7;  // Timeout and power-down are read-only.
  localparam int         LATCH_W       = 5;
  localparam int         GOTO_W        = 11;     // Address bits carried by a jump.

  // ------------------------------------------------------------------
  // Program side
  // ------------------------------------------------------------------
  localparam int          PC_W         = 13;
  localparam logic [12:0] RESET_VEC    = 13'h0000;
  localparam logic [12:0] INT_VEC      = 13'h0004;
  localparam logic [12:0] LAST_SMALL   = 13'h07ff;
  localparam logic [12:0] LAST_LARGE   = 13'h0fff;
  localparam logic [12:0] HEF_SMALL    = 13'h0780;
  localparam logic [12:0] HEF_LARGE    = 13'h0f80;

  typedef enum logic [1:0] {K_NONE, K_CORE, K_STORE} kind_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] idx;
  } dec_t;

  // One data access from the core.
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } data_req_t;

  // Program counter commands from the core.
  typedef struct packed {
    logic        step;
    logic        jump;
    logic        load;
    logic        int_take;
    logic [12:0] target;
  } pc_cmd_t;

endpackage

// [logic/banked_memory_map_decoder.sv]
// Purpose : Program counter and banked data memory decoder of a small core.
// Assumes : Core shares SYS_CLK_I and RESETN_I; one data access per cycle.
// Notes   : Reads answer one cycle after the request; peripheral offsets read zero here.
`timescale 1ns/1ns
module banked_memory_map_decoder #(
  parameter bit LARGE = 1'b1  // One selects the 4K word / 256 byte variant.
) (
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RESETN_I,
  input  wire memmap_pkg::data_req_t DATA_REQ_I,
  input  wire memmap_pkg::pc_cmd_t   PC_CMD_I,
  output logic [12:0]                PROG_ADDR_O,
  output logic                       HEF_O,
  output logic [7:0]                 RDATA_O,
  output logic                       RVALID_O,
  output logic [1:0]                 BANK_O,
  output logic [7:0]                 INT_CTRL_O
);
  import memmap_pkg::*;

  localparam logic [12:0] LAST_ADDR = LARGE ? LAST_LARGE : LAST_SMALL;
  localparam logic [12:0] HEF_START = LARGE ? HEF_LARGE : HEF_SMALL;
  localparam int          STORE_DEPTH = LARGE ? STORE_LARGE : STORE_SMALL;

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_q;  // First stage, read only by the second.
  logic rst_n;       // Released reset used by everything else.

  // The reset asserts at once but leaves on a clock edge to avoid a torn release.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  // Maps a bank and offset to a core register, a storage byte or nothing.
  function automatic dec_t decode(input logic [1:0] bank, input logic [6:0] off);
    dec_t d;
    d.kind = K_NONE;
    d.idx  = 8'h00;
    if (off == OFF_PC_LOW || off == OFF_STATUS || off == OFF_POINTER ||
        off == OFF_PC_LATCH || off == OFF_INT_CTRL) begin
      d.kind = K_CORE;
    end else if (off >= COMMON_BASE) begin
      d.kind = K_STORE;
      d.idx  = 8'(off) - 8'(STORE_BASE);
    end else if (off >= STORE_BASE) begin
      case (bank)
        2'd0: begin
          d.kind = K_STORE;
          d.idx  = 8'(off) - 8'(STORE_BASE);
        end
        2'd1: begin
          if (LARGE || off <= SMALL_B1_TOP) begin
            d.kind = K_STORE;
            d.idx  = B1_IDX_BASE + 8'(off) - 8'(STORE_BASE);
          end
        end
        2'd2: begin
          if (LARGE && off <= BANK_STORE_TOP) begin
            d.kind = K_STORE;
            d.idx  = B2_IDX_BASE + 8'(off) - 8'(STORE_BASE);
          end
        end
        default: begin
          d.kind = K_NONE;                                      // Bank 3 has no private storage.
        end
      endcase
    end
    return d;
  endfunction

  // Folds any program address into the implemented space.
  function automatic logic [12:0] wrap(input logic [12:0] a);
    return a & LAST_ADDR;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [12:0]         pc_q, pc_d;        // Program counter.
  logic [7:0]          status_q;          // Core status.
  logic [7:0]          pointer_q;         // Indirect pointer.
  logic [LATCH_W-1:0]  latch_q;           // Program counter latch high.
  logic [7:0]          int_ctrl_q;        // Interrupt control.
  logic [7:0]          store_q [STORE_DEPTH]; // General purpose storage.
  logic [1:0]          eff_bank;          // Bank after indirection.
  logic [6:0]          eff_off;           // Offset after indirection.
  logic                ind_use;           // Access goes through the pointer.
  dec_t                dec;               // Decoded target.
  logic                wr_core;           // Write strobe to a core register.

  // ------------------------------------------------------------------
  // Address resolution
  // ------------------------------------------------------------------
  // Offset zero is the indirect port: the pointer plus the high select bit then supply the address.
  always_comb begin
    ind_use = (DATA_REQ_I.addr == OFF_IND_PORT);
    if (ind_use) begin
      eff_bank = {status_q[ST_IRP], pointer_q[7]};
      eff_off  = pointer_q[6:0];
    end else begin
      eff_bank = {status_q[ST_BANK_HI], status_q[ST_BANK_LO]};
      eff_off  = DATA_REQ_I.addr;
    end
    dec     = decode(eff_bank, eff_off);
    wr_core = DATA_REQ_I.valid && DATA_REQ_I.wr && dec.kind == K_CORE;
  end

  // ------------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------------
  // Priority: interrupt, then a write to the low byte, then jump, load and step.
  always_comb begin
    pc_d = pc_q;
    if (PC_CMD_I.int_take) begin
      pc_d = INT_VEC;
    end else if (wr_core && eff_off == OFF_PC_LOW) begin
      pc_d = wrap({latch_q, DATA_REQ_I.wdata});
    end else if (PC_CMD_I.jump) begin
      pc_d = wrap({latch_q[LATCH_W-1:LATCH_W-2], PC_CMD_I.target[GOTO_W-1:0]});
    end else if (PC_CMD_I.load) begin
      pc_d = wrap(PC_CMD_I.target);
    end else if (PC_CMD_I.step) begin
      pc_d = wrap(pc_q + 13'h0001);
    end
  end

  // The counter and its endurance flag update together so they never disagree.
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pc_q  <= RESET_VEC;
      HEF_O <= 1'b0;
    end else begin
      pc_q  <= pc_d;
      HEF_O <= (pc_d >= HEF_START);
    end
  end

  assign PROG_ADDR_O = pc_q;

  // ------------------------------------------------------------------
  // Core registers
  // ------------------------------------------------------------------
  // Same offset in every bank lands on the same flop, so no bank switch is needed.
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
      pointer_q  <= 8'h00;
      latch_q    <= '0;
      int_ctrl_q <= 8'h00;
    end else if (wr_core) begin
      case (eff_off)
        OFF_STATUS: begin
          status_q <= (status_q & ~STATUS_WMASK) | (DATA_REQ_I.wdata & STATUS_WMASK);
        end
        OFF_POINTER: begin
          pointer_q <= DATA_REQ_I.wdata;
        end
        OFF_PC_LATCH: begin
          latch_q <= DATA_REQ_I.wdata[LATCH_W-1:0];
        end
        OFF_INT_CTRL: begin
          int_ctrl_q <= DATA_REQ_I.wdata;
        end
        default: begin
          pointer_q <= pointer_q;                               // Low byte handled above.
        end
      endcase
    end
  end

  assign BANK_O     = {status_q[ST_BANK_HI], status_q[ST_BANK_LO]};
  assign INT_CTRL_O = int_ctrl_q;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Storage is not reset; software must initialise it, as with any static RAM.
  always_ff @(posedge SYS_CLK_I) begin
    if (DATA_REQ_I.valid && DATA_REQ_I.wr && dec.kind == K_STORE) begin
      store_q[dec.idx] <= DATA_REQ_I.wdata;
    end
  end

  // ------------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------------
  // Unmapped offsets and the indirect port reached through itself read zero.
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O  <= 8'h00;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= DATA_REQ_I.valid && !DATA_REQ_I.wr;
      if (DATA_REQ_I.valid && !DATA_REQ_I.wr) begin
        RDATA_O <= 8'h00;
        if (dec.kind == K_STORE) begin
          RDATA_O <= store_q[dec.idx];
        end else if (dec.kind == K_CORE) begin
          case (eff_off)
            OFF_PC_LOW:   RDATA_O <= pc_q[7:0];
            OFF_STATUS:   RDATA_O <= status_q;
            OFF_POINTER:  RDATA_O <= pointer_q;
            OFF_PC_LATCH: RDATA_O <= 8'(latch_q);
            OFF_INT_CTRL: RDATA_O <= int_ctrl_q;
            default:      RDATA_O <= 8'h00;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!rst_n);

  a_reset_vector: assert property (@(posedge SYS_CLK_I) $rose(rst_n) |-> pc_q == RESET_VEC)
    else $error("Program counter not at reset vector after reset.");
  a_int_vector: assert property (PC_CMD_I.int_take |=> PROG_ADDR_O == INT_VEC)
    else $error("Interrupt did not reach its vector.");
  a_pc_wrap: assert property (PROG_ADDR_O <= LAST_ADDR)
    else $error("Program address outside implemented space.");
  a_pc_step: assert property (PC_CMD_I.step && !PC_CMD_I.jump && !PC_CMD_I.load && !PC_CMD_I.int_take
      && !wr_core |=> PROG_ADDR_O == wrap($past(PROG_ADDR_O) + 13'h0001))
    else $error("Step did not advance the counter by one.");
  a_hef_flag: assert property (HEF_O == (PROG_ADDR_O >= HEF_START))
    else $error("Endurance flag disagrees with program address.");
  a_bank_pick: assert property (DATA_REQ_I.valid && !ind_use |-> eff_bank == BANK_O)
    else $error("Direct access used the wrong bank.");
  a_regs_low: assert property (DATA_REQ_I.valid && eff_off < STORE_BASE |-> dec.kind != K_STORE)
    else $error("Storage decoded below the register area.");
  a_store_size: assert property (dec.kind == K_STORE |-> 32'(dec.idx) < STORE_DEPTH)
    else $error("Storage index beyond implemented bytes.");
  a_pointer_use: assert property (DATA_REQ_I.valid && ind_use |-> eff_off == pointer_q[6:0]
      && eff_bank == {status_q[ST_IRP], pointer_q[7]})
    else $error("Indirect access ignored the pointer.");
  a_core_mirror: assert property (wr_core && eff_off == OFF_POINTER |=> pointer_q == $past(DATA_REQ_I.wdata))
    else $error("Pointer write missed in some bank.");
  a_common_alias: assert property (DATA_REQ_I.valid && eff_off >= COMMON_BASE
      |-> dec.idx == 8'(eff_off) - 8'(STORE_BASE))
    else $error("Common area not shared with bank zero.");
  a_read_answer: assert property (DATA_REQ_I.valid && !DATA_REQ_I.wr |=> RVALID_O ##1 !RVALID_O || $past(DATA_REQ_I.valid))
    else $error("Read not answered in one cycle.");

  c_interrupt: cover property (PC_CMD_I.int_take ##1 PC_CMD_I.step);
  c_indirect_read: cover property (DATA_REQ_I.valid && ind_use && !DATA_REQ_I.wr && dec.kind == K_STORE);
  c_common_b3: cover property (DATA_REQ_I.valid && eff_bank == 2'd3 && eff_off >= COMMON_BASE);
  c_pc_wrap: cover property (PROG_ADDR_O == LAST_ADDR && PC_CMD_I.step);

endmodule

// [sim/core_model.sv]
// Purpose : Behavioural CPU core that issues data accesses and counter commands.
// Assumes : Shares the core clock; one request per task call, one cycle long.
// Notes   : Requests change just after a rising edge and drop after the taking edge.
`timescale 1ns/1ns
module core_model (
  input  wire logic                 clk_i,
  output memmap_pkg::data_req_t     data_req_o,
  output memmap_pkg::pc_cmd_t       pc_cmd_o
);
  import memmap_pkg::*;
  // ------------------------------------------------------------------
  // Request drivers
  // ------------------------------------------------------------------
  initial begin
    data_req_o = '0;
    pc_cmd_o   = '0;
  end

  // One data access; the decoder takes it on the second edge waited for here.
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    data_req_o <= '{valid: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge clk_i);
    data_req_o <= '0;
  endtask

  // One counter command, held for exactly one cycle.
  task automatic pc(input pc_cmd_t c);
    @(posedge clk_i);
    pc_cmd_o <= c;
    @(posedge clk_i);
    pc_cmd_o <= '0;
  endtask
endmodule

// [sim/tb_top.sv]
// Purpose : Self-checking bench for the banked memory map decoder.
// Assumes : Default large variant; core model drives all requests.
// Notes   : Outputs are sampled 1 ns after the edge that updates them.
`timescale 1ns/1ns
module tb_top;
  import memmap_pkg::*;
  logic        clk   = 1'b0;  // Core clock, 100 ns period.
  logic        rst_n = 1'b0;  // Active-low reset to the block.
  data_req_t   req;           // Data access from the core model.
  pc_cmd_t     cmd;           // Counter command from the core model.
  logic [12:0] pc;
  logic        hef;
  logic [7:0]  rd;
  logic        rv;
  logic [1:0]  bank;
  logic [7:0]  ic;
  int          fails       = 0;
  int          comparisons = 0;

  core_model core (.clk_i(clk), .data_req_o(req), .pc_cmd_o(cmd));
  banked_memory_map_decoder uut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .DATA_REQ_I(req),
    .PC_CMD_I(cmd), .PROG_ADDR_O(pc), .HEF_O(hef), .RDATA_O(rd), .RVALID_O(rv),
    .BANK_O(bank), .INT_CTRL_O(ic));

  // ------------------------------------------------------------------
  // Clock, helpers
  // ------------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset is held two cycles, then three edges pass for the release flops.
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    core.acc(1'b1, a, d);
    #1;
  endtask

  // Read answers exactly one cycle later with a one-cycle valid pulse.
  task automatic rd8(input logic [6:0] a, input logic [7:0] exp);
    core.acc(1'b0, a, 8'h00);
    #1;
    check(13'(rv), 13'h0001);
    check(13'(rd), 13'(exp));
  endtask

  task automatic pcc(input logic s, j, l, i, input logic [12:0] t);
    core.pc('{step: s, jump: j, load: l, int_take: i, target: t});
    #1;
  endtask

  // Status write keeps the read-only flags at one.
  task automatic setb(input logic [1:0] b);
    wr(OFF_STATUS, {1'b0, b, 5'h00});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    check(pc, RESET_VEC);
    check(13'(hef), 13'h0000);
    check(13'(bank), 13'h0000);
    rd8(OFF_STATUS, STATUS_RST);
    rd8(OFF_POINTER, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_pc();
    pcc(1, 0, 0, 0, 13'h0000);
    check(pc, 13'h0001);
    pcc(0, 0, 1, 0, 13'h1fff);
    check(pc, LAST_LARGE);
    check(13'(hef), 13'h0001);
    pcc(1, 0, 0, 0, 13'h0000);
    check(pc, 13'h0000);
    pcc(0, 0, 1, 0, HEF_LARGE - 13'h0001);
    check(13'(hef), 13'h0000);
    pcc(0, 0, 1, 0, HEF_LARGE);
    check(13'(hef), 13'h0001);
    pcc(1, 1, 1, 1, 13'h0123);
    check(pc, INT_VEC);
    wr(OFF_PC_LATCH, 8'h0f);
    pcc(0, 1, 0, 0, 13'h0123);
    check(pc, 13'h0923);
    wr(OFF_PC_LOW, 8'h55);
    check(pc, 13'h0f55);
    rd8(OFF_PC_LOW, 8'h55);
    rd8(OFF_PC_LATCH, 8'h0f);
    do_reset();
    check(pc, RESET_VEC);
    $display("test program counter done");
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      setb(2'(b));
      check(13'(bank), 13'(b));
      wr(OFF_INT_CTRL, 8'(8'h10 + b));
      check(13'(ic), 13'(8'h10 + b));
      wr(7'(COMMON_BASE + b), 8'(8'hc0 + b));
    end
    for (int b = 0; b < 4; b++) begin
      setb(2'(b));
      rd8(OFF_STATUS, {1'b0, 2'(b), 5'h18});
      rd8(OFF_INT_CTRL, 8'h13);
      for (int k = 0; k < 4; k++) rd8(7'(COMMON_BASE + k), 8'(8'hc0 + k));
    end
    $display("test banks done");
  endtask

  // Fills every private storage byte with a unique value, bank 3 has none.
  task automatic t_gpr();
    for (int b = 0; b < 4; b++) begin
      setb(2'(b));
      for (int o = 32; o < 112; o++) wr(7'(o), 8'(b * 80 + o));
    end
    for (int b = 0; b < 4; b++) begin
      setb(2'(b));
      rd8(7'h01, 8'h00);
      for (int o = 32; o < 112; o++) rd8(7'(o), (b == 3) ? 8'h00 : 8'(b * 80 + o));
    end
    $display("test storage done");
  endtask

  task automatic t_indirect();
    setb(2'd0);
    wr(OFF_POINTER, 8'ha5);
    wr(OFF_IND_PORT, 8'h3c);
    setb(2'd1);
    rd8(7'h25, 8'h3c);
    rd8(OFF_IND_PORT, 8'h3c);
    wr(OFF_POINTER, 8'h04);
    rd8(OFF_IND_PORT, 8'h04);
    wr(OFF_POINTER, 8'h00);
    rd8(OFF_IND_PORT, 8'h00);
    $display("test indirect done");
  endtask

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_pc();
    t_banks();
    t_gpr();
    t_indirect();
    stop_test();
  end

  // The run needs about 1440 cycles; this limit leaves ample slack.
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule
